//--- rtl/hst_pkg.sv
package hst_pkg;
  localparam logic [3:0] ADDR_FIFO_STAT = 4'h0;
  localparam logic [3:0] ADDR_DATA      = 4'h1;
  localparam logic [3:0] ADDR_CTRL      = 4'h2;
  localparam logic [3:0] ADDR_WDOG      = 4'h3;
  localparam logic [3:0] ADDR_TIMING    = 4'h4;
  localparam logic [3:0] ADDR_CCH_TX    = 4'h5;
  localparam logic [3:0] ADDR_CCH_STAT  = 4'h6;
  localparam int CTRL_TX_EN  = 7;
  localparam int CTRL_RX_EN  = 6;
  localparam int CTRL_FILL   = 2;
  localparam logic [1:0] FILL_TRANSP = 2'h2;
  localparam int TIM_INT  = 6;
  localparam int TIM_CCHAN_TX_ENABLE = 5;
  localparam int TIM_CRS  = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TIM_RST  = 8'h00;
  localparam logic [7:0] WD_MASK  = 8'h1F;
  localparam logic [7:0] WD_KEY   = 8'h0A;
  localparam int WD_STAGES = 11;
  localparam logic [4:0] CCH_CHAN  = 5'h01;
  localparam logic [7:0] SLOT_BASE = 8'h10;
  localparam logic [3:0] TC_WIDE   = 4'h4;
  localparam logic [4:0] CHAN_OFS  = 5'h02;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int RXF_HIGH = 15;
  localparam int TXF_HIGH = 5;
  localparam logic [2:0] DLY_SINGLE = 3'h2;
  localparam logic [2:0] DLY_DOUBLE = 3'h4;
  localparam logic [1:0] RXS_EMPTY = 2'h0;
  localparam logic [1:0] RXS_SOME  = 2'h1;
  localparam logic [1:0] RXS_FULL  = 2'h2;
  localparam logic [1:0] RXS_HIGH  = 2'h3;
  localparam logic [1:0] TXS_FULL  = 2'h0;
  localparam logic [1:0] TXS_HIGH  = 2'h1;
  localparam logic [1:0] TXS_EMPTY = 2'h2;
  localparam logic [1:0] TXS_LOW   = 2'h3;
  localparam logic [1:0] RXB_PACKET = 2'h0;
  typedef struct packed {
    logic       internal;
    logic       cch_en;
    logic       crs;
    logic [3:0] tc;
    logic       transp;
    logic       tx_en;
    logic       rx_en;
  } hst_cfg_s;
endpackage

//--- rtl/hst_serial_port.sv
`timescale 1ns/1ns
// Operation
// RL1: Channel-1 reserved for control, never packet data
// RL2: Rate select: double-rate or bit-rate serial clock
// RL3: Internal mode uses selected timeslots, gates ignored
// RL4: Control-channel byte sent in channel-1 when enabled
// RL5: Channel-1 input captured every frame, both readable
// RL6: External mode gates enable tx and rx separately
// RL7: External: output on rise, sample on fall
// RL8: Gate changes take effect after current bit
// RL9: Transparent mode moves raw bytes via 19-byte FIFOs
// RL10: Short slots send only low bits
// RL11: Empty transmit FIFO repeats last written byte
// RL12: Short slots fill only high bits
// RL13: FIFO status stays meaningful in transparent mode
// RL14: Eleven-stage watchdog on frame pulses, write clears
// RL15: Watchdog output low after 2^10 pulses unserviced
// RL16: Bit 0 sent first, first bit into bit 0
// RL17: Status register fields, bits 1..0 low
// RL18: Received-byte status code of FIFO head; this block always reports the packet code (RXB_PACKET)
// RL19: Receive FIFO fill encoding
// RL20: Status updates only after clock-edge delay
// RL21: Transmit FIFO fill encoding
// RL22: Data register read pops oldest receive byte
// RL23: Timing select bit chooses external or internal
// RL24: Channel-1 output high impedance when disabled
// RL25: Status register read has no side effect
module hst_serial_port import hst_pkg::*; #(
  parameter int DEPTH = 19
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       core_ce,
  input  wire logic       cpu_sel,
  input  wire logic       cpu_wr_en,
  input  wire logic       cpu_rd_en,
  input  wire logic [3:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       serial_clock_in,
  input  wire logic       frame_pulse_in,
  input  wire logic       tx_clock_gate_n,
  input  wire logic       rx_clock_gate_n,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_out_oe_n,
  output logic            watchdog_out_n
);
  localparam int PW = $clog2(DEPTH + 1);
  if (DEPTH < 16 || DEPTH > 31) begin : g_depth_check
    $error("DEPTH out of range");
  end

  // Core domain registers
  logic [7:0]           ctrl_reg;
  logic [7:0]           timing_reg;
  logic [7:0]           cch_tx_reg;
  logic [7:0]           cch_stat_reg;
  logic [7:0]           tx_hold_reg;
  logic [WD_STAGES-1:0] wd_reg;
  logic [7:0]           tx_mem [DEPTH];
  logic [7:0]           rx_mem [DEPTH];
  logic [PW-1:0]        tx_wp_reg;
  logic [PW-1:0]        tx_rp_reg;
  logic [PW-1:0]        tx_cnt_reg;
  logic [PW-1:0]        rx_wp_reg;
  logic [PW-1:0]        rx_rp_reg;
  logic [PW-1:0]        rx_cnt_reg;
  logic [2:0]           dly_reg;
  logic [5:0]           stat_reg;
  logic [2:0]           take_sy;
  logic [2:0]           rxb_sy;
  logic [2:0]           cch_sy;
  logic [2:0]           fall_sy;
  logic [2:0]           fp_sy;

  // Link domain registers
  logic                 take_tgl;
  logic                 rxb_tgl;
  logic                 cch_tgl;
  logic                 fall_tgl;
  logic [7:0]           rx_byte_l;
  logic [7:0]           cch_byte_l;
  logic [7:0]           tx_sh;
  logic [7:0]           rx_sh;
  logic [7:0]           cch_sh;
  logic [3:0]           tx_left;
  logic [3:0]           rx_have;
  logic [7:0]           bit_cnt;
  logic                 phase;
  logic                 fp_d;
  logic                 rx_slot_q;
  logic                 cch_slot_q;
  logic                 cch_last_q;
  logic [1:0]           lrst;
  logic [1:0]           txg_s;
  logic [1:0]           rxg_s;
  logic [1:0]           fpl_s;
  hst_cfg_s             cfg_m;
  hst_cfg_s             cfg_s;
  hst_cfg_s             cfg_core;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Processor port decode
  wire wr          = cpu_sel & cpu_wr_en;
  wire rd          = cpu_sel & cpu_rd_en;
  wire wr_ctrl     = wr & (cpu_addr == ADDR_CTRL);
  wire wr_tim      = wr & (cpu_addr == ADDR_TIMING);
  wire wr_cch      = wr & (cpu_addr == ADDR_CCH_TX);
  wire wr_tx       = wr & (cpu_addr == ADDR_DATA);
  wire wd_kick     = wr & (cpu_addr == ADDR_WDOG) & ((cpu_wdata & WD_MASK) == WD_KEY); // [RL14]
  wire rd_rx       = rd & (cpu_addr == ADDR_DATA);
  wire take_ev     = take_sy[2] ^ take_sy[1];
  wire rxb_ev      = rxb_sy[2] ^ rxb_sy[1];
  wire cch_ev      = cch_sy[2] ^ cch_sy[1];
  wire fall_ev     = fall_sy[2] ^ fall_sy[1];
  wire fp_ev       = fp_sy[2] & ~fp_sy[1];
  wire tx_full     = tx_cnt_reg == PW'(DEPTH);
  wire tx_empty    = tx_cnt_reg == '0;
  wire rx_full     = rx_cnt_reg == PW'(DEPTH);
  wire rx_empty    = rx_cnt_reg == '0;
  wire transp      = ctrl_reg[CTRL_FILL +: 2] == FILL_TRANSP;
  wire tx_push     = wr_tx & ~tx_full;
  wire tx_pop      = take_ev & ~tx_empty;                     // [RL11]
  wire rx_push     = rxb_ev & ~rx_full;
  wire rx_pop      = rd_rx & ~rx_empty;                       // [RL22]
  wire fifo_access = tx_push | tx_pop | rx_push | rx_pop;
  wire dbl_rate    = timing_reg[TIM_INT] & ~timing_reg[TIM_CRS];
  wire [2:0] need  = dbl_rate ? DLY_DOUBLE : DLY_SINGLE;      // [RL20]

  // FIFO fill encodings, unchanged in transparent mode
  wire [1:0] rx_code = rx_empty ? RXS_EMPTY : rx_full ? RXS_FULL :
                       (rx_cnt_reg >= PW'(RXF_HIGH)) ? RXS_HIGH : RXS_SOME; // [RL19] [RL13]
  wire [1:0] tx_code = tx_full ? TXS_FULL : tx_empty ? TXS_EMPTY :
                       (tx_cnt_reg >= PW'(TXF_HIGH)) ? TXS_HIGH : TXS_LOW;  // [RL21] [RL13]
  // Protocol tagging is outside this block, so every byte is a packet byte
  wire [7:0] fifo_stat = {RXB_PACKET, stat_reg};              // [RL17] [RL18]
  wire [7:0] rd_mux = (cpu_addr == ADDR_FIFO_STAT) ? fifo_stat :
                      (cpu_addr == ADDR_DATA)      ? rx_mem[rx_rp_reg] :
                      (cpu_addr == ADDR_CTRL)      ? ctrl_reg :
                      (cpu_addr == ADDR_TIMING)    ? timing_reg :
                      (cpu_addr == ADDR_CCH_TX)    ? cch_tx_reg :
                      (cpu_addr == ADDR_CCH_STAT)  ? cch_stat_reg : 8'h00;

  assign cfg_core = '{internal: timing_reg[TIM_INT], cch_en: timing_reg[TIM_CCHAN_TX_ENABLE],
                      crs: timing_reg[TIM_CRS], tc: timing_reg[3:0], transp: transp,
                      tx_en: ctrl_reg[CTRL_TX_EN], rx_en: ctrl_reg[CTRL_RX_EN]};
  assign watchdog_out_n = ~wd_reg[WD_STAGES-1];               // [RL15]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= CTRL_RST;
      timing_reg <= TIM_RST;
      cch_tx_reg <= 8'h00;
      cpu_rdata  <= 8'h00;
    end else if (core_ce) begin
      if (wr_ctrl) ctrl_reg <= cpu_wdata;
      if (wr_tim) timing_reg <= cpu_wdata;
      if (wr_cch) cch_tx_reg <= cpu_wdata;                    // [RL5]
      if (rd) cpu_rdata <= rd_mux;                            // [RL25]
    end
  end

  // Event crossings: toggles through two flops, third flop only for the edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      take_sy <= 3'h0;
      rxb_sy  <= 3'h0;
      cch_sy  <= 3'h0;
      fall_sy <= 3'h0;
      fp_sy   <= 3'h0;
    end else if (core_ce) begin
      take_sy <= {take_sy[1:0], take_tgl};
      rxb_sy  <= {rxb_sy[1:0], rxb_tgl};
      cch_sy  <= {cch_sy[1:0], cch_tgl};
      fall_sy <= {fall_sy[1:0], fall_tgl};
      fp_sy   <= {fp_sy[1:0], frame_pulse_in};
    end
  end

  // Watchdog counts frame pulses in either timing mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) wd_reg <= '0;                                 // [RL14]
    else if (core_ce) begin
      if (wd_kick) wd_reg <= '0;                              // [RL14]
      else if (fp_ev) wd_reg <= wd_reg + 1'b1;                // [RL15]
    end
  end

  // Link bytes are stable a whole byte after the toggle, so a late capture is safe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cch_stat_reg <= 8'h00;
      tx_hold_reg  <= 8'h00;
    end else if (core_ce) begin
      if (cch_ev) cch_stat_reg <= cch_byte_l;                 // [RL5]
      if (tx_pop) tx_hold_reg <= tx_mem[tx_rp_reg];           // [RL11]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_cnt_reg <= '0;
    end else if (core_ce) begin
      if (tx_push) tx_wp_reg <= inc(tx_wp_reg);
      if (tx_pop) tx_rp_reg <= inc(tx_rp_reg);
      if (tx_push & ~tx_pop) tx_cnt_reg <= tx_cnt_reg + 1'b1;
      else if (tx_pop & ~tx_push) tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      rx_cnt_reg <= '0;
    end else if (core_ce) begin
      if (rx_push) rx_wp_reg <= inc(rx_wp_reg);               // [RL9]
      if (rx_pop) rx_rp_reg <= inc(rx_rp_reg);                // [RL22]
      if (rx_push & ~rx_pop) rx_cnt_reg <= rx_cnt_reg + 1'b1;
      else if (rx_pop & ~rx_push) rx_cnt_reg <= rx_cnt_reg - 1'b1;
    end
  end

  // Storage needs no reset; contents are gated by the counts
  always_ff @(posedge core_clk) begin
    if (core_ce && tx_push) tx_mem[tx_wp_reg] <= cpu_wdata;   // [RL9]
    if (core_ce && rx_push) rx_mem[rx_wp_reg] <= rx_byte_l;
  end

  // Status held back after any FIFO access until enough serial falling edges pass
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_reg  <= 3'h0;
      stat_reg <= {RXS_EMPTY, TXS_EMPTY, 2'b00};
    end else if (core_ce) begin
      if (fifo_access) dly_reg <= 3'h0;                       // [RL20]
      else if (fall_ev && dly_reg < need) dly_reg <= dly_reg + 1'b1;
      if (!fifo_access && dly_reg >= need) stat_reg <= {rx_code, tx_code, 2'b00}; // [RL17]
    end
  end

  // Link domain, clocked by the serial clock
  always_ff @(posedge serial_clock_in or negedge rst_n) begin
    if (!rst_n) lrst <= 2'b00;
    else lrst <= {lrst[0], 1'b1};
  end
  wire lrst_n = lrst[1];

  // Configuration is quasi-static, so per-bit two-flop sync is enough
  always_ff @(posedge serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_m <= '0;
      cfg_s <= '0;
      txg_s <= 2'b11;
      rxg_s <= 2'b11;
      fpl_s <= 2'b11;
      fp_d  <= 1'b1;
    end else begin
      cfg_m <= cfg_core;
      cfg_s <= cfg_m;
      txg_s <= {txg_s[0], tx_clock_gate_n};                   // [RL8]
      rxg_s <= {rxg_s[0], rx_clock_gate_n};                   // [RL8]
      fpl_s <= {fpl_s[0], frame_pulse_in};
      fp_d  <= fpl_s[1];
    end
  end

  wire       frame_ev = cfg_s.internal & fp_d & ~fpl_s[1];
  wire       dbl      = cfg_s.internal & ~cfg_s.crs;          // [RL2]
  wire       adv      = ~dbl | phase;                         // [RL2]
  wire [4:0] chan     = bit_cnt[7:3];
  wire       narrow   = cfg_s.tc < TC_WIDE;
  wire [3:0] grp_len  = (cfg_s.tc == 4'h0) ? 4'h1 : (cfg_s.tc == 4'h1) ? 4'h2 :
                        (cfg_s.tc == 4'h2) ? 4'h6 : (cfg_s.tc == 4'h3) ? 4'h7 : BYTE_BITS;
  wire       in_cch   = cfg_s.internal & (chan == CCH_CHAN);  // [RL1]
  wire       in_narrow = (bit_cnt >= SLOT_BASE) & (bit_cnt < SLOT_BASE + {4'h0, grp_len});
  wire       in_wide  = chan == ({1'b0, cfg_s.tc} - CHAN_OFS);
  wire       slot     = narrow ? in_narrow : in_wide;         // [RL3]
  wire       mode_ok  = cfg_s.transp & ~(cfg_s.internal & cfg_s.tc == 4'h0); // [RL9]
  wire       tx_on    = mode_ok & cfg_s.tx_en &
                        (cfg_s.internal ? slot & ~in_cch : ~txg_s[1]); // [RL3] [RL6] [RL23]
  wire       rx_on    = mode_ok & cfg_s.rx_en &
                        (cfg_s.internal ? slot & ~in_cch : ~rxg_s[1]); // [RL3] [RL6] [RL23]
  wire [3:0] eff_len  = (cfg_s.internal & narrow) ? grp_len : BYTE_BITS; // [RL10] [RL12]

  // Frame position in bit periods, double-rate clock advances every other edge
  always_ff @(posedge serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      phase   <= 1'b0;
      bit_cnt <= 8'h00;
    end else if (frame_ev) begin
      phase   <= 1'b0;
      bit_cnt <= 8'h00;
    end else begin
      phase   <= dbl & ~phase;                                // [RL2]
      if (adv && cfg_s.internal) bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Output changes on the rising edge only
  always_ff @(posedge serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      serial_data_out      <= 1'b1;
      serial_data_out_oe_n <= 1'b1;
      tx_sh                <= 8'h00;
      tx_left              <= 4'h0;
      take_tgl             <= 1'b0;
      rx_slot_q            <= 1'b0;
      cch_slot_q           <= 1'b0;
      cch_last_q           <= 1'b0;
    end else if (adv) begin
      rx_slot_q  <= rx_on;
      cch_slot_q <= in_cch;                                   // [RL5]
      cch_last_q <= in_cch & (bit_cnt[2:0] == 3'h7);
      if (tx_on) begin
        serial_data_out_oe_n <= 1'b0;                         // [RL7]
        if (tx_left == 4'h0) begin
          serial_data_out <= tx_hold_reg[0];                  // [RL16] [RL11]
          tx_sh           <= tx_hold_reg >> 1;
          tx_left         <= eff_len - 1'b1;                  // [RL10]
          take_tgl        <= ~take_tgl;
        end else begin
          serial_data_out <= tx_sh[0];                        // [RL16]
          tx_sh           <= tx_sh >> 1;
          tx_left         <= tx_left - 1'b1;
        end
      end else if (in_cch) begin
        serial_data_out      <= cch_tx_reg[bit_cnt[2:0]];     // [RL4]
        serial_data_out_oe_n <= ~cfg_s.cch_en;                // [RL24]
      end else begin
        serial_data_out_oe_n <= 1'b1;
        if (!cfg_s.transp) tx_left <= 4'h0;
      end
    end
  end

  // Input sampled on the falling edge, in the second half of a double-rate bit
  always_ff @(negedge serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      fall_tgl   <= 1'b0;
      rx_sh      <= 8'h00;
      rx_have    <= 4'h0;
      rx_byte_l  <= 8'h00;
      rxb_tgl    <= 1'b0;
      cch_sh     <= 8'h00;
      cch_byte_l <= 8'h00;
      cch_tgl    <= 1'b0;
    end else begin
      fall_tgl <= ~fall_tgl;                                  // [RL20]
      if (adv && rx_slot_q) begin
        if (rx_have == eff_len - 1'b1) begin
          rx_byte_l <= {serial_data_in, rx_sh[7:1]};          // [RL12] [RL16]
          rxb_tgl   <= ~rxb_tgl;
          rx_sh     <= 8'h00;
          rx_have   <= 4'h0;
        end else begin
          rx_sh   <= {serial_data_in, rx_sh[7:1]};            // [RL7]
          rx_have <= rx_have + 1'b1;
        end
      end else if (!cfg_s.transp) begin
        rx_have <= 4'h0;
      end
      if (adv && cch_slot_q) begin
        cch_sh <= {serial_data_in, cch_sh[7:1]};              // [RL5]
        if (cch_last_q) begin
          cch_byte_l <= {serial_data_in, cch_sh[7:1]};
          cch_tgl    <= ~cch_tgl;
        end
      end
    end
  end
endmodule // hst_serial_port

//--- tb/hst_serial_port_checker.sv
`timescale 1ns/1ns
module hst_serial_port_checker import hst_pkg::*; #(
  parameter int DEPTH = 19
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       core_ce,
  input wire logic       cpu_sel,
  input wire logic       cpu_wr_en,
  input wire logic       cpu_rd_en,
  input wire logic [3:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       serial_clock_in,
  input wire logic       frame_pulse_in,
  input wire logic       tx_clock_gate_n,
  input wire logic       rx_clock_gate_n,
  input wire logic       serial_data_in,
  input wire logic       serial_data_out,
  input wire logic       serial_data_out_oe_n,
  input wire logic       watchdog_out_n
);
  logic [7:0] timing_reg;
  wire logic  rd_any  = core_ce && cpu_sel && cpu_rd_en;
  wire logic  wr_any  = core_ce && cpu_sel && cpu_wr_en;
  wire logic  rd_stat = rd_any && cpu_addr == ADDR_FIFO_STAT;
  wire logic  tx_push = wr_any && cpu_addr == ADDR_DATA;
  wire logic  wd_key  = wr_any && cpu_addr == ADDR_WDOG && (cpu_wdata & WD_MASK) == WD_KEY;
  // Shadow copy of the timing register, only the mode bit is looked at
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) timing_reg <= TIM_RST;
    else if (wr_any && cpu_addr == ADDR_TIMING) timing_reg <= cpu_wdata;
  end
  status_low_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n) rd_stat |=> cpu_rdata[1:0] == 2'h0)
    else $error("status low bits not zero");
  rx_byte_code_a: assert property (
    @(posedge core_clk) disable iff (!rst_n) rd_stat |=> cpu_rdata[7:6] == RXB_PACKET)
    else $error("received byte status not packet code");
  read_data_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n) !rd_any |=> $stable(cpu_rdata))
    else $error("read data changed without a read");
  status_delay_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat ##1 tx_push ##1 rd_stat |=> cpu_rdata[3:2] == $past(cpu_rdata[3:2], 2))
    else $error("tx status updated without delay");
  watchdog_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n) wd_key |=> ##[0:1] watchdog_out_n)
    else $error("watchdog not cleared by key write");
  out_on_rise_a: assert property (
    @(posedge core_clk) disable iff (!rst_n) $changed(serial_data_out) |-> serial_clock_in)
    else $error("serial output changed off the rising edge");
  enable_on_rise_a: assert property (
    @(posedge core_clk) disable iff (!rst_n) $changed(serial_data_out_oe_n) |-> serial_clock_in)
    else $error("output enable changed off the rising edge");
  tx_gate_off_a: assert property (
    @(posedge serial_clock_in) disable iff (!rst_n)
    (!timing_reg[TIM_INT] && tx_clock_gate_n)[*5] |-> serial_data_out_oe_n)
    else $error("output driven with transmit gate closed");
endmodule // hst_serial_port_checker

bind hst_serial_port hst_serial_port_checker #(.DEPTH(DEPTH)) i_hst_serial_port_checker (.core_clk, .rst_n,
  .core_ce, .cpu_sel, .cpu_wr_en, .cpu_rd_en, .cpu_addr, .cpu_wdata, .cpu_rdata, .serial_clock_in,
  .frame_pulse_in, .tx_clock_gate_n, .rx_clock_gate_n, .serial_data_in, .serial_data_out,
  .serial_data_out_oe_n, .watchdog_out_n);

//--- tb/hst_line_model.sv
`timescale 1ns/1ns
module hst_line_model (
  input  wire logic       serial_clock_in,
  input  wire logic       serial_data_out,
  input  wire logic       serial_data_out_oe_n,
  input  wire logic       tx_on,
  input  wire logic       rx_on,
  input  wire logic       fp_on,
  input  wire logic       fp_long,
  output logic            frame_pulse_in,
  output logic            tx_clock_gate_n,
  output logic            rx_clock_gate_n,
  output logic            serial_data_in,
  output logic      [7:0] cap_byte,
  output int              cap_cnt,
  output int              fp_cnt
);
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [1:0] hold_reg;
  logic [4:0] fp_div;
  // Long frames give room for the control channel, short ones keep the watchdog run brief
  wire logic  fp_fire = fp_on && (fp_long ? fp_div == 5'h0 : frame_pulse_in);
  initial begin
    {frame_pulse_in, tx_clock_gate_n, rx_clock_gate_n, serial_data_in} = 4'hF;
    {cap_byte, shift_reg, bit_reg, hold_reg, fp_div} = '0;
  end
  // Gates move on the falling edge, away from the output edge, each on its own
  always @(negedge serial_clock_in) begin
    tx_clock_gate_n <= !tx_on;
    rx_clock_gate_n <= !rx_on;
    if (!serial_data_out_oe_n) begin // Mid-bit sample, first bit lands in bit 0
      shift_reg <= {serial_data_out, shift_reg[7:1]};
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == 3'h7) begin
        cap_byte <= {serial_data_out, shift_reg[7:1]};
        cap_cnt <= cap_cnt + 1;
      end
    end else begin // A released line ends the byte, so a cut burst is never counted
      bit_reg <= 3'h0;
    end
  end
  // Ones while the gate is open plus a short hold, then a toggling line so stale data never matches
  always @(posedge serial_clock_in) begin
    fp_div <= fp_div + 5'h1;
    frame_pulse_in <= !fp_fire;
    if (fp_fire) fp_cnt <= fp_cnt + 1;
    if (!rx_clock_gate_n) hold_reg <= 2'h3;
    else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
    serial_data_in <= (!rx_clock_gate_n || hold_reg != 2'h0) ? 1'b1 : !serial_data_in;
  end
endmodule // hst_line_model

//--- tb/hst_serial_port_bench.sv
`timescale 1ns/1ns
module hst_serial_port_bench import hst_pkg::*; ();
  logic       core_clk, serial_clock_in, rst_n, core_ce, cpu_sel, cpu_wr_en, cpu_rd_en;
  logic [3:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, cap_byte;
  logic       tx_on, rx_on, fp_on, fp_long, frame_pulse_in, tx_clock_gate_n, rx_clock_gate_n;
  logic       serial_data_in, serial_data_out, serial_data_out_oe_n, watchdog_out_n;
  int         cap_cnt, fp_cnt, fails, samples_checked, cycles, cap_mark;

  hst_serial_port #(.DEPTH(19)) i_hst_serial_port (.core_clk, .rst_n, .core_ce, .cpu_sel, .cpu_wr_en,
    .cpu_rd_en, .cpu_addr, .cpu_wdata, .cpu_rdata, .serial_clock_in, .frame_pulse_in, .tx_clock_gate_n,
    .rx_clock_gate_n, .serial_data_in, .serial_data_out, .serial_data_out_oe_n, .watchdog_out_n);
  hst_line_model i_hst_line_model (.serial_clock_in, .serial_data_out, .serial_data_out_oe_n, .tx_on,
    .rx_on, .fp_on, .fp_long, .frame_pulse_in, .tx_clock_gate_n, .rx_clock_gate_n, .serial_data_in, .cap_byte,
    .cap_cnt, .fp_cnt);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    serial_clock_in = 1'b0;
    #13;
    forever #40 serial_clock_in = ~serial_clock_in;
  end

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Ceiling well above the watchdog run, which dominates the test time
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  // Strobes stay up until the next call or idle, so accesses can run back to back
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {cpu_sel, cpu_wr_en, cpu_rd_en, cpu_addr, cpu_wdata} <= {1'b1, wr, !wr, a, d};
  endtask
  task automatic idle();
    @(negedge core_clk);
    {cpu_sel, cpu_wr_en, cpu_rd_en} <= 3'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    idle();
    @(negedge core_clk);
    chk8(what, exp, cpu_rdata);
  endtask
  task automatic wait_on(input bit frames, input int k);
    for (int i = 0; i < 30000 && (frames ? fp_cnt : cap_cnt) < k; i++) @(negedge core_clk);
  endtask
  function automatic logic [7:0] bval(input int i);
    return 8'(8'h05 + i * 8'h1F);
  endfunction

  initial begin
    rst_n = 1'b0;
    core_ce = 1'b1;
    {cpu_sel, cpu_wr_en, cpu_rd_en, cpu_addr, cpu_wdata} = '0;
    {tx_on, rx_on, fp_on, fp_long} = 4'h0;
    repeat (10) @(negedge core_clk);
    rst_n <= 1'b1;
    repeat (40) @(negedge core_clk);
    rd("status at reset", ADDR_FIFO_STAT, 8'h08);
    rd("unmapped read", 4'hF, 8'h00);
    wr(ADDR_CTRL, 8'hC8);
    bus(1'b0, ADDR_FIFO_STAT, 8'h00);
    bus(1'b1, ADDR_DATA, bval(0));
    rd("status right after push", ADDR_FIFO_STAT, 8'h08);
    for (int i = 1; i < 20; i++) begin
      wr(ADDR_DATA, bval(i));
      if (i == 3 || i == 4 || i == 19) begin
        repeat (40) @(negedge core_clk);
        rd("tx fill", ADDR_FIFO_STAT, i == 3 ? 8'h0C : i == 4 ? 8'h04 : 8'h00);
      end
    end
    tx_on <= 1'b1;
    // One-byte hold stage: the first byte out is the empty hold, the FIFO head follows it
    for (int k = 0; k < 3; k++) begin
      wait_on(1'b0, k + 2);
      chk8("tx byte", bval(k), cap_byte);
    end
    wait_on(1'b0, 22);
    chk8("tx repeat", bval(18), cap_byte);
    tx_on <= 1'b0;
    repeat (60) @(negedge core_clk);
    rd("tx drained", ADDR_FIFO_STAT, 8'h08);
    rx_on <= 1'b1;
    repeat (160) @(negedge core_clk);
    rx_on <= 1'b0;
    repeat (60) @(negedge core_clk);
    rd("rx fill", ADDR_FIFO_STAT, 8'h18);
    rd("rx byte", ADDR_DATA, 8'hFF);
    rd("rx byte", ADDR_DATA, 8'hFF);
    repeat (40) @(negedge core_clk);
    rd("rx empty", ADDR_FIFO_STAT, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CCH_TX, 8'h5A);
    rd("cchan tx readback", ADDR_CCH_TX, 8'h5A);
    {fp_long, fp_on, rx_on} <= 3'h7;
    wr(ADDR_TIMING, 8'h75);
    wait_on(1'b0, cap_cnt + 2);
    chk8("cchan byte", 8'h5A, cap_byte);
    rd("cchan status", ADDR_CCH_STAT, 8'hFF);
    wr(ADDR_TIMING, 8'h55);
    repeat (400) @(negedge core_clk);
    cap_mark = cap_cnt;
    repeat (800) @(negedge core_clk);
    chk8("cchan muted", 8'(cap_mark), 8'(cap_cnt));
    {fp_long, fp_on, rx_on} <= 3'h0;
    repeat (20) @(negedge core_clk);
    wr(ADDR_WDOG, 8'hEA);
    fp_on <= 1'b1;
    wait_on(1'b1, fp_cnt + 1000);
    chk1("watchdog early", 1'b1, watchdog_out_n);
    wait_on(1'b1, fp_cnt + 40);
    chk1("watchdog expired", 1'b0, watchdog_out_n);
    wr(ADDR_WDOG, 8'h1A);
    chk1("watchdog wrong key", 1'b0, watchdog_out_n);
    wr(ADDR_WDOG, 8'hEA);
    chk1("watchdog cleared", 1'b1, watchdog_out_n);
    final_report();
  end
endmodule // hst_serial_port_bench
